// ---- src/uv_pkg.sv ----
// constants and types shared by the undervoltage alarm stage
package uv_pkg;
	localparam int         MAG_W         = 16;
	localparam int         SETS          = 8;
	localparam int         LOG_DEPTH     = 12;
	localparam int         DIV_STEPS     = 24;
	localparam int         CLK_HZ        = 200000000;
	localparam int         STAMP_MS      = 1;
	localparam int         MS_CYCLES     = CLK_HZ / 1000 * STAMP_MS;
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_STATUS    = 8'h04;
	localparam logic [7:0] OFF_COUNT     = 8'h08;
	localparam logic [7:0] OFF_TIME      = 8'h0c;
	localparam logic [7:0] OFF_LOG_SEL   = 8'h10;
	localparam logic [7:0] OFF_LOG_TIME  = 8'h14;
	localparam logic [7:0] OFF_LOG_INFO  = 8'h18;
	localparam logic [7:0] OFF_SET_BASE  = 8'h40;
	localparam logic [7:0] OFF_SET_END   = 8'h80;
	// thresholds in steps of 0.01 % of nominal
	localparam logic [15:0] UV_THR_RST   = 16'h07d0;
	localparam logic [15:0] NV_THR_RST   = 16'h0064;
	localparam logic        VTYPE_RST    = 1'h0;
	localparam logic [1:0]  PICK_RST     = 2'h0;
	localparam logic [1:0]  CTRL_RST     = 2'h3;
	localparam logic [23:0] PCT_BASE     = 24'h000064;
	localparam logic [23:0] HYST_PCT     = 24'h000067;
	// event block identity, value is arbitrary
	localparam logic [7:0]  EVENT_BLOCK_ONE = 8'h01;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	localparam int POS_ALARM  = 0;
	localparam int POS_NOVOLT = 1;
	localparam int POS_EXTBLK = 2;
	localparam int POS_INTBLK = 3;
	localparam int POS_UVLOW  = 4;
	localparam int POS_NVLOW  = 7;
	localparam int POS_SET    = 10;
	localparam int POS_FILL   = 16;
	localparam int POS_EV     = 0;
	localparam int POS_PH     = 2;
	localparam int POS_LSET   = 5;
	localparam int POS_VALID  = 8;
	localparam int POS_RATIO  = 16;
	typedef enum logic [1:0] {
		EV_ALARM_ON  = 2'h0,
		EV_ALARM_OFF = 2'h1,
		EV_NV_ON     = 2'h2,
		EV_NV_OFF    = 2'h3
	} evcode_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_DIV   = 3'b010,
		ST_WRITE = 3'b100
	} logst_t;
endpackage

// ---- src/uv_level_cmp.sv ----
// one level comparator with pick-up below threshold and 103 % release
`timescale 1ns/1ps
`default_nettype none
module uv_level_cmp (
	// clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     rst,
	// measurement
	input  wire logic                     en,
	input  wire logic [uv_pkg::MAG_W-1:0] mag,
	input  wire logic [uv_pkg::MAG_W-1:0] thr,
	// result
	output logic                          below
);
	import uv_pkg::*;

	logic        next_below;
	logic [23:0] magPct;
	logic [23:0] thrHyst;

	always_comb begin
		magPct = 24'(mag) * PCT_BASE;
		thrHyst = 24'(thr) * HYST_PCT;
		next_below = below;
		if (en && !below && mag < thr) begin
			next_below = 1'b1;
		end else if (en && below && magPct > thrHyst) begin
			next_below = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			below <= 1'b0;
		end else begin
			below <= next_below;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	AST_PICKUP: assert property (en && mag < thr |=> below)
		else $error("level below threshold not picked up");
	AST_HOLD: assert property (below && !(en && magPct > thrHyst) |=> below)
		else $error("released without reaching 103 percent");
endmodule
`default_nettype wire

// ---- src/undervoltage_alarm_stage.sv ----
// undervoltage alarm stage with axi4-lite settings, event log and alarm counter
// Overview of operation
// - three rms magnitudes are evaluated on every 5 ms measurement update strobe.
// - pick-up when a measured voltage falls below the minimum threshold.
// - a voltage recovers only above 103 % of the threshold.
// - one threshold serves all three voltages.
// - undervoltage threshold in 0.01 % steps, default 20 % of nominal.
// - separate no-voltage threshold in 0.01 % steps, default 1 % of nominal.
// - type selector 0 picks phase-to-phase, 1 phase-to-earth voltages.
// - pick-up count code 0, 1, 2 needs one, two, three low voltages.
// - internal block from measurement and external block input are honoured.
// - eight setting sets, one shared selector, switchable while running.
// - on and off events for alarm and no-voltage changes.
// - option forwards on events, off events or both to the event buffer.
// - twelve newest events logged, oldest overwritten.
// - entry holds time, event, phases, voltage to threshold ratio, active set.
// - timestamps resolve to 1 ms.
// - cumulative alarm count, cleared by software.
// - alarm drives output control and user logic.
`timescale 1ns/1ps
`default_nettype none
module undervoltage_alarm_stage #(
	parameter int MS_CYCLES = uv_pkg::MS_CYCLES
) (
	// clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     rst,
	// axi4-lite register bus
	input  wire logic [7:0]               awaddr,
	input  wire logic                     awvalid,
	output logic                          awready,
	input  wire logic [31:0]              wdata,
	input  wire logic [3:0]               wstrb,
	input  wire logic                     wvalid,
	output logic                          wready,
	output logic [1:0]                    bresp,
	output logic                          bvalid,
	input  wire logic                     bready,
	input  wire logic [7:0]               araddr,
	input  wire logic                     arvalid,
	output logic                          arready,
	output logic [31:0]                   rdata,
	output logic [1:0]                    rresp,
	output logic                          rvalid,
	input  wire logic                     rready,
	// measurement front end
	input  wire logic                     measUpdate,
	input  wire logic [uv_pkg::MAG_W-1:0] magPp1,
	input  wire logic [uv_pkg::MAG_W-1:0] magPp2,
	input  wire logic [uv_pkg::MAG_W-1:0] magPp3,
	input  wire logic [uv_pkg::MAG_W-1:0] magPe1,
	input  wire logic [uv_pkg::MAG_W-1:0] magPe2,
	input  wire logic [uv_pkg::MAG_W-1:0] magPe3,
	// blocking and setting set selection
	input  wire logic                     extBlock,
	input  wire logic [2:0]               activeSettingSet,
	// alarm outputs
	output logic                          alarm,
	output logic                          alarmLogic,
	output logic                          noVoltage,
	// event buffer
	output logic                          evValid,
	output logic [7:0]                    evBlock,
	output logic [1:0]                    evCode,
	output logic [31:0]                   evStamp
);
	import uv_pkg::*;

	function automatic logic [31:0] strbMerge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction

	logic [15:0] uvThr [SETS];
	logic [15:0] nvThr [SETS];
	logic        vType [SETS];
	logic [1:0]  pickCnt [SETS];
	logic [15:0] next_uvThr [SETS];
	logic [15:0] next_nvThr [SETS];
	logic        next_vType [SETS];
	logic [1:0]  next_pickCnt [SETS];
	logic        awHeld, wHeld, next_awHeld, next_wHeld;
	logic [7:0]  awAddr, next_awAddr;
	logic [31:0] wData, next_wData, merged;
	logic [3:0]  wStrb, next_wStrb;
	logic        next_bvalid, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata, rdWord, statusWord;
	logic        rdErr, doWrite, setHit, cntClr, timeWr;
	logic [2:0]  setIdx;
	logic [1:0]  ctrlMask, next_ctrlMask;
	logic [3:0]  logSel, next_logSel;
	logic [31:0] msCnt, next_msCnt, msTime, next_msTime;
	logic        msTick;
	logic [15:0] magSel [3];
	logic [15:0] curUvThr, curNvThr, minMag;
	logic [1:0]  pickCur, need, uvCnt;
	logic [2:0]  uvBelow, nvBelow;
	logic        intBlock, evalDly, next_alarm, next_noVoltage;
	logic [3:0]  newEv, pend, next_pend, clrMask;
	logic [31:0] alarmCount, next_alarmCount;
	logst_t      st, next_st;
	logic [1:0]  pick, curEv, next_curEv;
	logic [23:0] dvd, next_dvd;
	logic [15:0] dvs, next_dvs, rem, next_rem, ratio;
	logic [16:0] trial;
	logic [4:0]  step, next_step, rdPos;
	logic [2:0]  phases, next_phases, setCap, next_setCap;
	logic [31:0] stampCap, next_stampCap, infoWord;
	logic [3:0]  head, next_head, fill, next_fill, rdIdx;
	logic        next_evValid, fwdOk;
	logic [31:0] logTime [LOG_DEPTH];
	logic [31:0] logInfo [LOG_DEPTH];

	// register bus
	assign awready = !awHeld && !bvalid;
	assign wready = !wHeld && !bvalid;
	assign arready = !rvalid;
	assign doWrite = awHeld && wHeld && !bvalid;
	assign setHit = awAddr >= OFF_SET_BASE && awAddr < OFF_SET_END;
	assign setIdx = awAddr[5:3];

	always_comb begin
		statusWord = 32'h0;
		statusWord[POS_ALARM] = alarm;
		statusWord[POS_NOVOLT] = noVoltage;
		statusWord[POS_EXTBLK] = extBlock;
		statusWord[POS_INTBLK] = intBlock;
		statusWord[POS_UVLOW +: 3] = uvBelow;
		statusWord[POS_NVLOW +: 3] = nvBelow;
		statusWord[POS_SET +: 3] = activeSettingSet;
		statusWord[POS_FILL +: 4] = fill;
		rdWord = 32'h0;
		rdErr = 1'b0;
		if (araddr >= OFF_SET_BASE && araddr < OFF_SET_END) begin
			if (araddr[2]) begin
				rdWord = {29'h0, pickCnt[araddr[5:3]], vType[araddr[5:3]]};
			end else begin
				rdWord = {nvThr[araddr[5:3]], uvThr[araddr[5:3]]};
			end
		end else begin
			case (araddr)
				OFF_CTRL: rdWord = {30'h0, ctrlMask};
				OFF_STATUS: rdWord = statusWord;
				OFF_COUNT: rdWord = alarmCount;
				OFF_TIME: rdWord = msTime;
				OFF_LOG_SEL: rdWord = {28'h0, logSel};
				OFF_LOG_TIME: rdWord = (logSel < fill) ? logTime[rdIdx] : 32'h0;
				OFF_LOG_INFO: rdWord = (logSel < fill) ? logInfo[rdIdx] : 32'h0;
				default: rdErr = 1'b1;
			endcase
		end
	end

	always_comb begin
		next_awHeld = awHeld;
		next_wHeld = wHeld;
		next_awAddr = awAddr;
		next_wData = wData;
		next_wStrb = wStrb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		next_ctrlMask = ctrlMask;
		next_logSel = logSel;
		next_uvThr = uvThr;
		next_nvThr = nvThr;
		next_vType = vType;
		next_pickCnt = pickCnt;
		cntClr = 1'b0;
		timeWr = 1'b0;
		merged = 32'h0;
		if (awvalid && awready) begin
			next_awHeld = 1'b1;
			next_awAddr = awaddr;
		end
		if (wvalid && wready) begin
			next_wHeld = 1'b1;
			next_wData = wdata;
			next_wStrb = wstrb;
		end
		if (doWrite) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			if (awAddr == OFF_CTRL) begin
				merged = strbMerge({30'h0, ctrlMask}, wData, wStrb);
				next_ctrlMask = merged[1:0];
			end else if (awAddr == OFF_COUNT) begin
				cntClr = 1'b1;
			end else if (awAddr == OFF_TIME) begin
				timeWr = 1'b1;
			end else if (awAddr == OFF_LOG_SEL) begin
				merged = strbMerge({28'h0, logSel}, wData, wStrb);
				next_logSel = merged[3:0];
			end else if (setHit && !awAddr[2]) begin
				merged = strbMerge({nvThr[setIdx], uvThr[setIdx]}, wData, wStrb);
				next_uvThr[setIdx] = merged[15:0];
				next_nvThr[setIdx] = merged[31:16];
			end else if (setHit) begin
				merged = strbMerge({29'h0, pickCnt[setIdx], vType[setIdx]}, wData, wStrb);
				next_vType[setIdx] = merged[0];
				next_pickCnt[setIdx] = merged[2:1];
			end else if (awAddr != OFF_STATUS && awAddr != OFF_LOG_TIME
					&& awAddr != OFF_LOG_INFO) begin
				next_bresp = RESP_SLVERR;
			end
		end else if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rdata = rdWord;
			next_rresp = rdErr ? RESP_SLVERR : RESP_OKAY;
		end else if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
	end

	// millisecond time base
	always_comb begin
		msTick = msCnt == 32'(MS_CYCLES - 1);
		next_msCnt = msTick ? 32'h0 : msCnt + 32'h1;
		next_msTime = msTime;
		if (timeWr) begin
			next_msTime = strbMerge(msTime, wData, wStrb);
		end else if (msTick) begin
			next_msTime = msTime + 32'h1;
		end
	end

	// magnitude selection and comparison
	always_comb begin
		curUvThr = uvThr[activeSettingSet];
		curNvThr = nvThr[activeSettingSet];
		pickCur = pickCnt[activeSettingSet];
		magSel[0] = vType[activeSettingSet] ? magPe1 : magPp1;
		magSel[1] = vType[activeSettingSet] ? magPe2 : magPp2;
		magSel[2] = vType[activeSettingSet] ? magPe3 : magPp3;
		minMag = magSel[0];
		for (int m = 1; m < 3; m++) begin
			if (magSel[m] < minMag) begin
				minMag = magSel[m];
			end
		end
	end

	for (genvar i = 0; i < 3; i++) begin : g_cmp
		uv_level_cmp uvCmp (
			.clk_sys (clk_sys),
			.rst     (rst),
			.en      (measUpdate),
			.mag     (magSel[i]),
			.thr     (curUvThr),
			.below   (uvBelow[i])
		);
		uv_level_cmp nvCmp (
			.clk_sys (clk_sys),
			.rst     (rst),
			.en      (measUpdate),
			.mag     (magSel[i]),
			.thr     (curNvThr),
			.below   (nvBelow[i])
		);
	end

	// alarm, no-voltage and counter
	always_comb begin
		need = (pickCur == 2'h0) ? 2'h1 : (pickCur == 2'h1) ? 2'h2 : 2'h3;
		uvCnt = {1'b0, uvBelow[0]} + {1'b0, uvBelow[1]} + {1'b0, uvBelow[2]};
		intBlock = &nvBelow;
		next_alarm = alarm && !extBlock;
		next_noVoltage = noVoltage;
		if (evalDly) begin
			next_alarm = uvCnt >= need && !extBlock && !intBlock;
			next_noVoltage = &nvBelow;
		end
		newEv = {noVoltage & ~next_noVoltage, ~noVoltage & next_noVoltage,
			alarm & ~next_alarm, ~alarm & next_alarm};
		next_alarmCount = cntClr ? 32'h0 : alarmCount;
		if (newEv[EV_ALARM_ON]) begin
			next_alarmCount = next_alarmCount + 32'h1;
		end
	end
	assign alarmLogic = alarm;

	// event log sequencer with ratio divider
	always_comb begin
		pick = 2'h0;
		for (int k = 3; k >= 0; k--) begin
			if (pend[k]) begin
				pick = 2'(k);
			end
		end
		trial = {rem, dvd[23]};
		clrMask = 4'h0;
		next_st = st;
		next_curEv = curEv;
		next_dvd = dvd;
		next_dvs = dvs;
		next_rem = rem;
		next_step = step;
		next_phases = phases;
		next_setCap = setCap;
		next_stampCap = stampCap;
		unique case (st)
			ST_IDLE: begin
				if (|pend) begin
					clrMask[pick] = 1'b1;
					next_curEv = pick;
					next_dvd = {minMag, 8'h00};
					next_dvs = pick[1] ? curNvThr : curUvThr;
					next_phases = pick[1] ? nvBelow : uvBelow;
					next_setCap = activeSettingSet;
					next_stampCap = msTime;
					next_rem = 16'h0;
					next_step = 5'h0;
					next_st = ST_DIV;
				end
			end
			ST_DIV: begin
				if (trial >= {1'b0, dvs}) begin
					next_rem = 16'(trial - {1'b0, dvs});
					next_dvd = {dvd[22:0], 1'b1};
				end else begin
					next_rem = trial[15:0];
					next_dvd = {dvd[22:0], 1'b0};
				end
				next_step = step + 5'h1;
				if (step == 5'(DIV_STEPS - 1)) begin
					next_st = ST_WRITE;
				end
			end
			ST_WRITE: begin
				next_st = ST_IDLE;
			end
		endcase
		next_pend = (pend & ~clrMask) | newEv;
		ratio = (dvs == 16'h0 || |dvd[23:16]) ? 16'hffff : dvd[15:0];
		infoWord = 32'h0;
		infoWord[POS_EV +: 2] = curEv;
		infoWord[POS_PH +: 3] = phases;
		infoWord[POS_LSET +: 3] = setCap;
		infoWord[POS_VALID] = 1'b1;
		infoWord[POS_RATIO +: 16] = ratio;
		next_head = head;
		next_fill = fill;
		if (st == ST_WRITE) begin
			next_head = (head == 4'(LOG_DEPTH - 1)) ? 4'h0 : head + 4'h1;
			next_fill = (fill == 4'(LOG_DEPTH)) ? fill : fill + 4'h1;
		end
		fwdOk = ctrlMask[curEv[0]];
		next_evValid = st == ST_WRITE && fwdOk;
		rdPos = 5'(head) + 5'(LOG_DEPTH - 1) - 5'(logSel);
		rdIdx = (rdPos >= 5'(LOG_DEPTH)) ? 4'(rdPos - 5'(LOG_DEPTH)) : rdPos[3:0];
	end

	always_ff @(posedge clk_sys) begin
		if (st == ST_WRITE) begin
			logTime[head] <= stampCap;
			logInfo[head] <= infoWord;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int s = 0; s < SETS; s++) begin
				uvThr[s] <= UV_THR_RST;
				nvThr[s] <= NV_THR_RST;
				vType[s] <= VTYPE_RST;
				pickCnt[s] <= PICK_RST;
			end
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 8'h00;
			wData <= 32'h0;
			wStrb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= 32'h0;
			ctrlMask <= CTRL_RST;
			logSel <= 4'h0;
			msCnt <= 32'h0;
			msTime <= 32'h0;
			evalDly <= 1'b0;
			alarm <= 1'b0;
			noVoltage <= 1'b0;
			alarmCount <= 32'h0;
			pend <= 4'h0;
			st <= ST_IDLE;
			curEv <= 2'h0;
			dvd <= 24'h0;
			dvs <= 16'h0;
			rem <= 16'h0;
			step <= 5'h0;
			phases <= 3'h0;
			setCap <= 3'h0;
			stampCap <= 32'h0;
			head <= 4'h0;
			fill <= 4'h0;
			evValid <= 1'b0;
			evBlock <= EVENT_BLOCK_ONE;
			evCode <= 2'h0;
			evStamp <= 32'h0;
		end else begin
			uvThr <= next_uvThr;
			nvThr <= next_nvThr;
			vType <= next_vType;
			pickCnt <= next_pickCnt;
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awAddr <= next_awAddr;
			wData <= next_wData;
			wStrb <= next_wStrb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			ctrlMask <= next_ctrlMask;
			logSel <= next_logSel;
			msCnt <= next_msCnt;
			msTime <= next_msTime;
			evalDly <= measUpdate;
			alarm <= next_alarm;
			noVoltage <= next_noVoltage;
			alarmCount <= next_alarmCount;
			pend <= next_pend;
			st <= next_st;
			curEv <= next_curEv;
			dvd <= next_dvd;
			dvs <= next_dvs;
			rem <= next_rem;
			step <= next_step;
			phases <= next_phases;
			setCap <= next_setCap;
			stampCap <= next_stampCap;
			head <= next_head;
			fill <= next_fill;
			evValid <= next_evValid;
			evBlock <= EVENT_BLOCK_ONE;
			evCode <= (st == ST_WRITE) ? curEv : evCode;
			evStamp <= (st == ST_WRITE) ? stampCap : evStamp;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	AST_EVAL_ONLY: assert property ($rose(alarm) |-> $past(evalDly))
		else $error("alarm rose outside an evaluation");
	AST_PICK_COUNT: assert property ($rose(alarm) |-> $past(uvCnt) >= $past(need))
		else $error("alarm rose with too few low voltages");
	AST_BLOCK_EXT: assert property (extBlock |=> !alarm)
		else $error("alarm high while externally blocked");
	AST_BLOCK_INT: assert property ($rose(alarm) |-> !$past(intBlock))
		else $error("alarm rose while internally blocked");
	AST_NV_FOLLOW: assert property (evalDly |=> noVoltage == $past(intBlock))
		else $error("no-voltage output not updated");
	AST_EVENT_ON: assert property ($rose(alarm) |-> pend[EV_ALARM_ON])
		else $error("alarm on event missing");
	AST_FORWARD: assert property (evValid |-> $past(fwdOk) && $past(st) == ST_WRITE)
		else $error("event forwarded against the mask");
	AST_LOG_DONE: assert property (st == ST_IDLE && |pend |-> ##25 st == ST_WRITE)
		else $error("log entry not written in 25 cycles");
	AST_LOG_WRAP: assert property (st == ST_WRITE && head == 4'hb |=> head == 4'h0)
		else $error("log pointer did not wrap");
	AST_COUNT: assert property ($rose(alarm) && !$past(cntClr)
			|-> alarmCount == $past(alarmCount) + 32'h1)
		else $error("alarm count not incremented");
	AST_MS_STEP: assert property (msTick && !timeWr |=> msTime == $past(msTime) + 32'h1)
		else $error("millisecond time did not advance");
endmodule
`default_nettype wire

// ---- verif/meas_frontend.sv ----
// behavioural measurement front end driving rms magnitudes
`timescale 1ns/1ps
`default_nettype none
module meas_frontend #(
	parameter int PERIOD = 64
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// levels to present
	input  wire logic [47:0] ppLv,
	input  wire logic [47:0] peLv,
	// measurement outputs
	output logic             measUpdate,
	output logic [47:0]      pp,
	output logic [47:0]      pe
);
	int cnt;
	// shortened update period stands in for the 5 ms base
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			measUpdate <= 1'h0;
			pp <= 48'h0;
			pe <= 48'h0;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			measUpdate <= (cnt == PERIOD - 1);
			// both voltage kinds always supplied
			if (cnt == PERIOD - 1) begin
				pp <= ppLv;
				pe <= peLv;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking testbench for the undervoltage alarm stage
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import uv_pkg::*;
	localparam logic [15:0] HI = 16'h2710;
	localparam logic [47:0] AH = {3{HI}};
	localparam logic [15:0] LO = 16'h07cf;
	logic        clk_sys = 1'h0;
	logic        rst = 1'h1;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 1'h0;
	logic        wvalid = 1'h0;
	logic        bready = 1'h0;
	logic        arvalid = 1'h0;
	logic        rready = 1'h0;
	logic        extBlock = 1'h0;
	logic [2:0]  activeSettingSet = 3'h0;
	logic [47:0] ppLv = AH;
	logic [47:0] peLv = AH;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        measUpdate, alarm, alarmLogic, noVoltage, evValid;
	logic [1:0]  bresp, rresp, evCode, lastEv, r;
	logic [31:0] rdata, evStamp, d, t, lastStamp;
	logic [47:0] pp, pe;
	logic [7:0]  evBlock;
	int          mismatches = 0;
	int          samples_checked = 0;
	int          evCount = 0;
	always #2.5 clk_sys = ~clk_sys;
	meas_frontend fe (.clk_sys, .rst, .ppLv, .peLv, .measUpdate, .pp, .pe);
	undervoltage_alarm_stage #(.MS_CYCLES(20)) dut (.clk_sys, .rst, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .measUpdate,
		.magPp1(pp[15:0]), .magPp2(pp[31:16]), .magPp3(pp[47:32]), .magPe1(pe[15:0]),
		.magPe2(pe[31:16]), .magPe3(pe[47:32]), .extBlock, .activeSettingSet, .alarm,
		.alarmLogic, .noVoltage, .evValid, .evBlock, .evCode, .evStamp);
	always @(posedge clk_sys) begin
		if (evValid === 1'h1) begin
			lastEv <= evCode;
			lastStamp <= evStamp;
			evCount <= evCount + 1;
		end
	end
	task automatic final_report();
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic hang();
		mismatches++;
		final_report();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("ERROR %0t got %h expected %h", $time, got, exp);
			mismatches++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int   n;
		logic ta, tw, tb;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk_sys);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			r = bresp;
			@(posedge clk_sys);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			if (tb) begin
				bready <= 1'h0;
				return;
			end
		end
		hang();
	endtask
	task automatic rd(input logic [7:0] a);
		int   n;
		logic ta, tb;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk_sys);
			ta = arvalid & arready;
			tb = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_sys);
			if (ta) arvalid <= 1'h0;
			if (tb) begin
				rready <= 1'h0;
				return;
			end
		end
		hang();
	endtask
	// new levels, then wait out one update and its event logging
	task automatic lv(input logic [47:0] p, input logic [47:0] e);
		int n;
		@(posedge clk_sys);
		ppLv <= p;
		peLv <= e;
		@(negedge clk_sys);
		for (n = 0; n < 200; n++) begin
			@(negedge clk_sys);
			if (measUpdate === 1'h1) break;
		end
		if (n == 200) hang();
		else repeat (40) @(posedge clk_sys);
	endtask
	task automatic scDefaults();
		rd(OFF_CTRL);
		chk(d, 32'h3);
		rd(OFF_SET_BASE);
		chk(d, 32'h006407d0);
		rd(OFF_SET_BASE + 8'h04);
		chk(d, 32'h0);
		rd(8'h30);
		chk({d[29:0], r}, {30'h0, RESP_SLVERR});
		wr(8'h30, 32'h1);
		chk(r, RESP_SLVERR);
		wr(OFF_TIME, 32'h100);
		rd(OFF_TIME);
		chk(d - 32'h100 <= 32'h1, 1'h1);
		chk(evBlock, EVENT_BLOCK_ONE);
	endtask
	task automatic scPick();
		lv({HI, HI, LO}, AH);
		chk(alarm, 1'h1);
		chk(alarmLogic, 1'h1);
		chk(lastEv, EV_ALARM_ON);
		lv({HI, HI, 16'h080c}, AH);
		chk(alarm, 1'h1);
		lv({HI, HI, 16'h080d}, AH);
		chk({alarm, lastEv}, {1'h0, EV_ALARM_OFF});
		rd(OFF_COUNT);
		chk(d, 32'h1);
		wr(OFF_COUNT, 32'h0);
		rd(OFF_COUNT);
		chk(d, 32'h0);
	endtask
	task automatic scTerms();
		wr(OFF_SET_BASE + 8'h04, 32'h2);
		lv({HI, HI, LO}, AH);
		chk(alarm, 1'h0);
		lv({HI, LO, LO}, AH);
		chk(alarm, 1'h1);
		lv(AH, AH);
		wr(OFF_SET_BASE + 8'h04, 32'h4);
		lv({HI, LO, LO}, AH);
		chk(alarm, 1'h0);
		lv({3{LO}}, AH);
		chk(alarm, 1'h1);
		lv(AH, AH);
		chk(alarm, 1'h0);
		wr(OFF_SET_BASE + 8'h04, 32'h1);
		lv(AH, {HI, LO, HI});
		chk(alarm, 1'h1);
		lv(AH, AH);
		wr(OFF_SET_BASE + 8'h04, 32'h0);
		wr(OFF_SET_BASE + 8'h08, 32'h00640bb8);
		activeSettingSet <= 3'h1;
		lv({HI, HI, 16'h09c4}, AH);
		chk(alarm, 1'h1);
		activeSettingSet <= 3'h0;
		lv(AH, AH);
	endtask
	task automatic scBlock();
		lv({HI, LO, HI}, AH);
		extBlock <= 1'h1;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(alarm, 1'h0);
		lv({HI, LO, HI}, AH);
		chk(alarm, 1'h0);
		extBlock <= 1'h0;
		lv(AH, AH);
		lv({3{16'h0032}}, AH);
		chk({noVoltage, alarm}, 2'h2);
		rd(OFF_STATUS);
		chk(d[15:0], 16'h03fa);
		lv({3{16'h0067}}, AH);
		chk(noVoltage, 1'h1);
		lv({3{16'h0068}}, AH);
		chk(noVoltage, 1'h0);
		lv(AH, AH);
	endtask
	task automatic scForward();
		int c;
		wr(OFF_CTRL, 32'h1);
		c = evCount;
		lv({LO, HI, HI}, AH);
		lv(AH, AH);
		chk(evCount - c, 32'h1);
		chk(lastEv, EV_ALARM_ON);
		wr(OFF_LOG_SEL, 32'h0);
		rd(OFF_LOG_INFO);
		chk({d[8:5], d[1:0]}, {1'h1, 3'h0, EV_ALARM_OFF});
		rd(OFF_LOG_TIME);
		t = d;
		wr(OFF_LOG_SEL, 32'h1);
		rd(OFF_LOG_INFO);
		chk({d[31:16], d[4:0]}, {16'h00ff, 3'h4, EV_ALARM_ON});
		rd(OFF_LOG_TIME);
		chk(d, lastStamp);
		chk(t - d - 32'h3 <= 32'h1, 1'h1);
		wr(OFF_CTRL, 32'h2);
		c = evCount;
		lv({LO, HI, HI}, AH);
		lv(AH, AH);
		chk(evCount - c, 32'h1);
		chk(lastEv, EV_ALARM_OFF);
		wr(OFF_CTRL, 32'h3);
	endtask
	initial begin
		#200000;
		hang();
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'h0;
		scDefaults();
		scPick();
		scTerms();
		scBlock();
		scForward();
		final_report();
	end
endmodule
`default_nettype wire
